// [core/gst_timer.sv]
// gated sixteen bit timer: counter, prescaler, gate and avalon-mm slave.
// assumes one core clock; every pin input crosses through gst_sync.
//
// Notes on behaviour
// - sixteen-bit up counter, high and low bytes, writes load immediately.
// - source select 0 counts instruction clock, 1 counts external clock.
// - internal source advances once per instruction cycle times prescale.
// - external rising edges increment, either synchronized or asynchronous.
// - falling edge needed first after reset, counter write, or high disable.
// - prescaler divides selected input by one, two, four or eight.
// - prescale field 00,01,10,11 means divide by 1,2,4,8.
// - prescaler is hidden from software and cleared by counter writes.
// - crystal runs when enabled, also in sleep, only in allowed modes.
// - crystal enabled in an allowed mode forces pin directions to 1, port bits read 0.
// - sync bypass with external source counts asynchronously, runs in sleep, overflow can wake.
// - mode switch may drop one increment or add one spurious increment.
// - byte reads during asynchronous counting always return valid bytes.
// - gate comes from gate pin or second comparator, chosen elsewhere.
// - selected gate applies only while gate enable is set.
// - timer on counts while gate active if enabled, else always.
// - gate invert bit flips gate polarity for either source.
// - invert 1 means active high gate, 0 means active low.
// - overflow flag sets when counter rolls from ffff to 0000.
// - interrupt requested only with timer, peripheral, global enables set.
// - sleep counting only asynchronous; overflow wakes core with enables.
// - increment clock is offered out for comparator synchronization.
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// two flip-flop synchroniser; the first stage feeds only the second
module gst_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             CLK,
	input  wire logic             RST_B,
	input  wire logic [WIDTH-1:0] D,
	output logic      [WIDTH-1:0] Q
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			stage1 <= '0;
			Q      <= '0;
		end else begin
			stage1 <= D;
			Q      <= stage1;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////
module gst_timer #(
	parameter int INSTR_DIV = gst_pkg::INSTR_DIV
) (
	input  wire logic        CORE_CLK,
	input  wire logic        RST_B,
	input  wire logic [4:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	input  wire logic        EXT_COUNT_CLOCK_PIN,
	input  wire logic        LOW_POWER_CRYSTAL_OSC,
	input  wire logic        GATE_INPUT_PIN,
	input  wire logic        SECOND_COMPARATOR_OUTPUT,
	input  wire logic [1:0]  OSC_PORT_PINS,
	input  wire logic        OSC_MODE_OK,
	input  wire logic        SLEEP,
	output logic             INC_TICK,
	output logic             OVERFLOW_IRQ,
	output logic             WAKE,
	output logic             CRYSTAL_OSC_RUN,
	output logic             OSC_IN_PIN_DIRECTION,
	output logic             OSC_OUT_PIN_DIRECTION
);

	////////////////////////////////////////////////////////////////////////
	// declarations
	gst_pkg::gst_control_t  control;
	gst_pkg::gst_irq_ctrl_t irq_ctrl;
	logic [15:0] count;
	logic        overflow_flag;
	logic [2:0]  prescale;
	// divider width follows the parameter so a slower core can reuse it
	localparam int DIV_W = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;
	logic [DIV_W-1:0] instr_cnt;
	logic        armed;
	logic        pending;
	logic        on_d;
	logic        src_d;
	logic        xtal_d;
	logic        src_swap;
	logic        ack;
	logic [5:0]  pins_s;
	logic        ext_s;
	logic        lp_s;
	logic        gate_s;
	logic        comp_s;
	logic [1:0]  port_s;
	logic        src_level;
	logic        src_rise;
	logic        src_fall;
	logic        q_tick;
	logic        raw_tick;
	logic [2:0]  pre_mask;
	logic        pre_out;
	logic        gate_raw;
	logic        gate_active;
	logic        run_ok;
	logic        async_mode;
	logic        count_inc;
	logic        rollover;
	logic        req;
	logic        wr_fire;
	logic        wr_low;
	logic        wr_high;
	logic        count_wr;
	logic [31:0] next_readdata;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisation
	gst_sync #(
		.WIDTH(6)
	) u_pin_sync (
		.CLK   (CORE_CLK),
		.RST_B (RST_B),
		.D     ({OSC_PORT_PINS, SECOND_COMPARATOR_OUTPUT, GATE_INPUT_PIN,
		         LOW_POWER_CRYSTAL_OSC, EXT_COUNT_CLOCK_PIN}),
		.Q     (pins_s)
	);

	assign ext_s  = pins_s[0];
	assign lp_s   = pins_s[1];
	assign gate_s = pins_s[2];
	assign comp_s = pins_s[3];
	assign port_s = pins_s[5:4];

	////////////////////////////////////////////////////////////////////////
	// avalon-mm handshake: one wait state, answer at the second edge
	assign req             = AVS_READ | AVS_WRITE;
	assign AVS_WAITREQUEST = req & ~ack;
	assign wr_fire         = AVS_WRITE & ack & AVS_BYTEENABLE[0];
	assign wr_low  = wr_fire & (AVS_ADDRESS == gst_pkg::ADDR_COUNT_LOW);
	assign wr_high = wr_fire & (AVS_ADDRESS == gst_pkg::ADDR_COUNT_HI);
	assign count_wr = wr_low | wr_high;

	// ack lasts one cycle, so a request still held after its answer is
	// taken again with a fresh wait; the master must drop it at that edge
	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			ack <= 1'b0;
		end else begin
			ack <= req & ~ack;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control and irq registers
	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			control  <= gst_pkg::CONTROL_RESET;
			irq_ctrl <= gst_pkg::IRQ_CTRL_RESET;
		end else if (wr_fire) begin
			if (AVS_ADDRESS == gst_pkg::ADDR_CONTROL) begin
				control <= AVS_WRITEDATA[7:0];
			end
			if (AVS_ADDRESS == gst_pkg::ADDR_IRQ_CTRL) begin
				irq_ctrl <= AVS_WRITEDATA[3:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// crystal oscillator and its pins
	// the crystal is ignored unless the system clock mode allows it
	assign CRYSTAL_OSC_RUN = control.crystal_osc_enable & OSC_MODE_OK;
	assign OSC_IN_PIN_DIRECTION  = CRYSTAL_OSC_RUN;
	assign OSC_OUT_PIN_DIRECTION = CRYSTAL_OSC_RUN;

	// start-up delay is left to software; no ready flag exists here

	////////////////////////////////////////////////////////////////////////
	// clock source and edge detection
	assign src_level = CRYSTAL_OSC_RUN ? lp_s : ext_s;
	assign src_rise  = src_level & ~src_d;
	assign src_fall  = ~src_level & src_d;

	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			src_d  <= 1'b0;
			on_d   <= 1'b0;
			xtal_d <= 1'b0;
		end else begin
			src_d  <= src_level;
			on_d   <= control.timer_on;
			xtal_d <= CRYSTAL_OSC_RUN;
		end
	end

	// swapping pin and crystal can fake a rising edge; treat it as a
	// fresh start that needs a falling edge again
	assign src_swap = CRYSTAL_OSC_RUN ^ xtal_d;

	// instruction clock is the core clock over INSTR_DIV, four by default, and halts in sleep
	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			instr_cnt <= '0;
		end else if (!SLEEP) begin
			// wrap explicitly so a divide that is not a power of two holds
			if (instr_cnt == DIV_W'(INSTR_DIV - 1)) begin
				instr_cnt <= '0;
			end else begin
				instr_cnt <= instr_cnt + DIV_W'(1);
			end
		end
	end

	assign q_tick = ~SLEEP & (instr_cnt == DIV_W'(INSTR_DIV - 1));

	// a rising edge only counts once a falling edge has been seen
	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			armed <= 1'b0;
		end else if (count_wr) begin
			armed <= 1'b0;
		end else if (on_d & ~control.timer_on & src_level) begin
			armed <= 1'b0;
		end else if (src_swap) begin
			armed <= 1'b0;
		end else if (control.timer_on & src_fall) begin
			armed <= 1'b1;
		end
	end

	assign raw_tick = control.source_select
	                ? (src_rise & armed & ~src_swap)
	                : q_tick;

	////////////////////////////////////////////////////////////////////////
	// gate
	assign gate_raw = irq_ctrl.gate_source_select ? comp_s : gate_s;
	assign gate_active = control.gate_invert ? gate_raw : ~gate_raw;
	assign run_ok = control.timer_on
	              & (~control.gate_enable | gate_active);

	////////////////////////////////////////////////////////////////////////
	// prescaler, not visible to software
	always_comb begin
		case (control.prescale_select)
			2'h0:    pre_mask = gst_pkg::PRE_MASK_1;
			2'h1:    pre_mask = gst_pkg::PRE_MASK_2;
			2'h2:    pre_mask = gst_pkg::PRE_MASK_4;
			2'h3:    pre_mask = gst_pkg::PRE_MASK_8;
			default: pre_mask = gst_pkg::PRE_MASK_1;
		endcase
	end

	assign pre_out = run_ok & raw_tick
	               & ((prescale & pre_mask) == pre_mask);

	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			prescale <= 3'h0;
		end else if (count_wr) begin
			prescale <= 3'h0;
		end else if (run_ok & raw_tick) begin
			prescale <= prescale + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sync or async increment
	// external clock with bypass set is the only path alive in sleep
	assign async_mode = control.source_select & control.sync_bypass;

	// the synchronized path holds a prescaled edge until the next
	// instruction tick; switching to async mode drops it
	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			pending <= 1'b0;
		end else if (count_wr | async_mode | ~run_ok) begin
			pending <= 1'b0;
		end else begin
			pending <= (pending | pre_out) & ~q_tick;
		end
	end

	assign count_inc = async_mode ? pre_out
	                 : (run_ok & (pending | pre_out) & q_tick);
	assign INC_TICK = count_inc;

	////////////////////////////////////////////////////////////////////////
	// counter; a write wins over a same-cycle increment
	// writing while counting can lose that increment, so stop first
	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			count <= 16'h0000;
		end else if (wr_low) begin
			count[7:0] <= AVS_WRITEDATA[7:0];
		end else if (wr_high) begin
			count[15:8] <= AVS_WRITEDATA[7:0];
		end else if (count_inc) begin
			count <= count + 16'h0001;
		end
	end

	assign rollover = count_inc & ~count_wr
	                & (count == gst_pkg::COUNT_MAX);

	////////////////////////////////////////////////////////////////////////
	// overflow flag: hardware only sets it, a set beats a software clear
	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			overflow_flag <= 1'b0;
		end else if (rollover) begin
			overflow_flag <= 1'b1;
		end else if (wr_fire & (AVS_ADDRESS == gst_pkg::ADDR_FLAG)) begin
			overflow_flag <= AVS_WRITEDATA[gst_pkg::FLAG_OVERFLOW_BIT];
		end
	end

	assign OVERFLOW_IRQ = overflow_flag & irq_ctrl.overflow_irq_enable
	                    & irq_ctrl.peripheral_irq_enable
	                    & irq_ctrl.global_irq_enable;

	// wake needs no global enable; the core vectors only if it is set
	assign WAKE = SLEEP & control.timer_on & overflow_flag
	            & irq_ctrl.overflow_irq_enable
	            & irq_ctrl.peripheral_irq_enable;

	////////////////////////////////////////////////////////////////////////
	// read data, captured in the wait cycle so it stands at the answer
	// the count lives in the core domain, so each byte read is whole
	always_comb begin
		next_readdata = 32'h0000_0000;
		case (AVS_ADDRESS)
			gst_pkg::ADDR_CONTROL:   next_readdata[7:0] = control;
			gst_pkg::ADDR_COUNT_LOW: next_readdata[7:0] = count[7:0];
			gst_pkg::ADDR_COUNT_HI:  next_readdata[7:0] = count[15:8];
			gst_pkg::ADDR_FLAG:
				next_readdata[gst_pkg::FLAG_OVERFLOW_BIT] = overflow_flag;
			gst_pkg::ADDR_IRQ_CTRL:  next_readdata[3:0] = irq_ctrl;
			gst_pkg::ADDR_STATUS: begin
				next_readdata[gst_pkg::ST_OSC_IN_DIR_BIT]  = OSC_IN_PIN_DIRECTION;
				next_readdata[gst_pkg::ST_OSC_OUT_DIR_BIT] = OSC_OUT_PIN_DIRECTION;
				next_readdata[gst_pkg::ST_OSC_IN_PORT_BIT] =
					port_s[0] & ~CRYSTAL_OSC_RUN;
				next_readdata[gst_pkg::ST_OSC_OUT_PORT_BIT] =
					port_s[1] & ~CRYSTAL_OSC_RUN;
				next_readdata[gst_pkg::ST_CRYSTAL_RUN_BIT] = CRYSTAL_OSC_RUN;
			end
			default: next_readdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			AVS_READDATA <= 32'h0000_0000;
		end else if (AVS_READ & ~ack) begin
			AVS_READDATA <= next_readdata;
		end
	end

endmodule

`default_nettype wire

// [core/gst_pkg.sv]
// package for the gated sixteen bit timer: register map, field layout,
// reset values and timing counts.
// assumes a 32-bit avalon-mm slave decode, one register per aligned word.
`default_nettype none

package gst_pkg;

	////////////////////////////////////////////////////////////////////////
	// register byte addresses
	localparam logic [4:0] ADDR_CONTROL   = 5'h00;
	localparam logic [4:0] ADDR_COUNT_LOW = 5'h04;
	localparam logic [4:0] ADDR_COUNT_HI  = 5'h08;
	localparam logic [4:0] ADDR_FLAG      = 5'h0c;
	localparam logic [4:0] ADDR_IRQ_CTRL  = 5'h10;
	localparam logic [4:0] ADDR_STATUS    = 5'h14;

	////////////////////////////////////////////////////////////////////////
	// timer_control_reg layout, bit 7 down to bit 0
	typedef struct packed {
		logic       gate_invert;
		logic       gate_enable;
		logic [1:0] prescale_select;
		logic       crystal_osc_enable;
		logic       sync_bypass;
		logic       source_select;
		logic       timer_on;
	} gst_control_t;

	// irq control word, bit 3 down to bit 0
	typedef struct packed {
		logic gate_source_select;
		logic global_irq_enable;
		logic peripheral_irq_enable;
		logic overflow_irq_enable;
	} gst_irq_ctrl_t;

	localparam gst_control_t  CONTROL_RESET  = 8'h00;
	localparam gst_irq_ctrl_t IRQ_CTRL_RESET = 4'h8;

	// field positions in the flag and status words
	localparam int FLAG_OVERFLOW_BIT  = 0;
	localparam int ST_OSC_IN_DIR_BIT  = 0;
	localparam int ST_OSC_OUT_DIR_BIT = 1;
	localparam int ST_OSC_IN_PORT_BIT = 2;
	localparam int ST_OSC_OUT_PORT_BIT = 3;
	localparam int ST_CRYSTAL_RUN_BIT = 4;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CORE_CLK_HZ     = 20_000_000;
	localparam int INSTR_DIV       = 4;
	localparam int CRYSTAL_HZ      = 32_768;
	localparam logic [15:0] COUNT_MAX   = 16'hffff;
	localparam logic [2:0]  PRE_MASK_1  = 3'h0;
	localparam logic [2:0]  PRE_MASK_2  = 3'h1;
	localparam logic [2:0]  PRE_MASK_4  = 3'h3;
	localparam logic [2:0]  PRE_MASK_8  = 3'h7;

endpackage

`default_nettype wire

// [dv/gst_timer_assertions.sv]
// checker for gst_timer: bus handshake, tick shape, oscillator and wake
// assumes it sees only the top ports; bound to every gst_timer instance
`default_nettype none

////////////////////////////////////////
module gst_timer_checker #(
	parameter int INSTR_DIV = 4
) (
	input wire logic        CORE_CLK,
	input wire logic        RST_B,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        AVS_WAITREQUEST,
	input wire logic        SLEEP,
	input wire logic        OSC_MODE_OK,
	input wire logic        INC_TICK,
	input wire logic        OVERFLOW_IRQ,
	input wire logic        WAKE,
	input wire logic        CRYSTAL_OSC_RUN,
	input wire logic        OSC_IN_PIN_DIRECTION,
	input wire logic        OSC_OUT_PIN_DIRECTION
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);

	read_wait_a: assert property ($rose(AVS_READ) |->
		AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("read wait");
	write_wait_a: assert property ($rose(AVS_WRITE) |->
		AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("write wait");
	rdata_hold_a: assert property (!AVS_READ |=>
		$stable(AVS_READDATA)) else $error("read data moved");
	osc_dir_a: assert property (CRYSTAL_OSC_RUN |->
		OSC_IN_PIN_DIRECTION && OSC_OUT_PIN_DIRECTION) else $error("osc dir");
	crystal_mode_a: assert property (CRYSTAL_OSC_RUN |->
		OSC_MODE_OK) else $error("crystal in wrong mode");
	tick_pulse_a: assert property (INC_TICK |=>
		!INC_TICK) else $error("tick longer than one cycle");
	wake_sleep_a: assert property (WAKE |->
		SLEEP) else $error("wake while awake");
	// a request may only appear after an increment tick or a register write
	irq_cause_a: assert property ($rose(OVERFLOW_IRQ) |->
		$past(INC_TICK) || $past(AVS_WRITE && !AVS_WAITREQUEST))
		else $error("irq without cause");
endmodule

bind gst_timer gst_timer_checker #(.INSTR_DIV(INSTR_DIV)) chk_i (
	.CORE_CLK(CORE_CLK), .RST_B(RST_B), .AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .SLEEP(SLEEP),
	.OSC_MODE_OK(OSC_MODE_OK), .INC_TICK(INC_TICK),
	.OVERFLOW_IRQ(OVERFLOW_IRQ), .WAKE(WAKE),
	.CRYSTAL_OSC_RUN(CRYSTAL_OSC_RUN),
	.OSC_IN_PIN_DIRECTION(OSC_IN_PIN_DIRECTION),
	.OSC_OUT_PIN_DIRECTION(OSC_OUT_PIN_DIRECTION));
`default_nettype wire

// [dv/gst_far_side.sv]
// far side model: external count clock burst and a free crystal level
// assumes GO is a one-cycle request; PIN idles at the level it ended on
`default_nettype none

////////////////////////////////////////
module gst_far_side (
	input  wire logic       CLK,
	input  wire logic       GO,
	input  wire logic [7:0] N,
	output var  logic       PIN,
	output logic            BUSY,
	output var  logic       XTAL
);
	timeunit 1ns;
	timeprecision 1ns;
	int edges = 0;
	int ph = 0;
	initial begin
		PIN = 1'b0;
		XTAL = 1'b0;
	end
	assign BUSY = edges != 0;
	// the crystal free-runs, it is not stopped between bursts
	always @(posedge CLK) begin
		ph <= ph + 1;
		if (ph % 4 == 3)
			XTAL <= !XTAL;
		// slow edges so each level outlasts the synchroniser
		if (GO && edges == 0)
			edges <= 2 * N;
		else if (edges != 0 && ph % 8 == 7) begin
			PIN <= !PIN;
			edges <= edges - 1;
		end
	end
endmodule
`default_nettype wire

// [dv/gst_timer_bench.sv]
// self-checking bench for gst_timer with a tick-driven count model
// assumes the checker binds itself and gst_far_side drives the count clock and crystal pins
`default_nettype none

module gst_timer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [4:0]  addr = 5'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  be = 4'hf;
	logic        gate_pin = 1'b1;
	logic        cmp_out = 1'b0;
	logic        mode_ok = 1'b0;
	logic        sleep = 1'b0;
	logic        go = 1'b0;
	logic [7:0]  n_edges = 8'h00;
	logic [31:0] rdata, q;
	logic        waitreq, ext_pin, xtal, busy, tick, irq, wake, xrun;
	int          bad_count = 0;
	int          total_checks = 0;
	int          mcount = 0;
	int          ticks = 0;
	int          t0;

	always #25 clk = !clk;

	gst_timer #(.INSTR_DIV(4)) dut (.CORE_CLK(clk), .RST_B(rst_b),
		.AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(waitreq), .EXT_COUNT_CLOCK_PIN(ext_pin),
		.LOW_POWER_CRYSTAL_OSC(xtal), .GATE_INPUT_PIN(gate_pin),
		.SECOND_COMPARATOR_OUTPUT(cmp_out), .OSC_PORT_PINS(2'h3),
		.OSC_MODE_OK(mode_ok), .SLEEP(sleep), .INC_TICK(tick),
		.OVERFLOW_IRQ(irq), .WAKE(wake), .CRYSTAL_OSC_RUN(xrun),
		.OSC_IN_PIN_DIRECTION(), .OSC_OUT_PIN_DIRECTION());
	gst_far_side far (.CLK(clk), .GO(go), .N(n_edges), .PIN(ext_pin),
		.BUSY(busy), .XTAL(xtal));

	// model: a 16-bit count advanced by every tick
	always @(negedge clk) begin
		if (tick === 1'b1) begin
			ticks++;
			mcount = (mcount + 1) & 16'hffff;
		end
	end

	task automatic chk(input logic [31:0] got, input int exp);
		total_checks++;
		if (got !== 32'(exp)) begin
			bad_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= {24'h0, d};
		wr <= w;
		rd <= !w;
		// waitrequest and read data are taken at the same rising edge
		do @(posedge clk); while (waitreq !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		if (w && be[0] && a == gst_pkg::ADDR_COUNT_LOW)
			mcount = (mcount & 16'hff00) | d;
		if (w && be[0] && a == gst_pkg::ADDR_COUNT_HI)
			mcount = (mcount & 16'h00ff) | (d << 8);
		@(posedge clk);
	endtask

	task automatic rdchk(input logic [4:0] a, input int exp);
		bus(1'b0, a, 8'h00);
		chk(q, exp);
	endtask

	task automatic cnt_chk;
		rdchk(gst_pkg::ADDR_COUNT_LOW, mcount & 8'hff);
		rdchk(gst_pkg::ADDR_COUNT_HI, mcount >> 8);
	endtask

	// skip one possibly odd interval after a setting change
	task automatic gap(input int exp);
		int c;
		c = 0;
		repeat (2) begin
			@(negedge clk);
			while (tick !== 1'b1) @(negedge clk);
		end
		do begin
			@(negedge clk);
			c++;
		end while (tick !== 1'b1);
		chk(c, exp);
		// hand back on a rising edge so the next bus call starts cleanly
		@(posedge clk);
	endtask

	task automatic ext(input logic [7:0] n);
		n_edges <= n;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		do @(negedge clk); while (busy);
		repeat (16) @(posedge clk);
	endtask

	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge clk);
		bad_count++;
		tally_and_finish();
	end

	initial begin
		void'($urandom(55));
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rdchk(gst_pkg::ADDR_CONTROL, 0);
		rdchk(gst_pkg::ADDR_IRQ_CTRL, 8);
		rdchk(gst_pkg::ADDR_FLAG, 0);
		bus(1'b1, 5'h18, 8'hff);
		rdchk(5'h18, 0);
		be <= 4'he;
		bus(1'b1, gst_pkg::ADDR_COUNT_LOW, 8'h5a);
		be <= 4'hf;
		cnt_chk();
		$display("test reset done");
		// the comparator is the gate source from reset and idles active, so ticks here do not prove the gate is ignored
		for (int ps = 0; ps < 4; ps++) begin
			bus(1'b1, gst_pkg::ADDR_CONTROL, 8'(ps << 4) | 8'h01);
			gap(4 << ps);
		end
		bus(1'b1, gst_pkg::ADDR_CONTROL, 8'h00);
		cnt_chk();
		$display("test prescale done");
		for (int i = 0; i < 8; i++) begin
			gate_pin <= i[2] ? 1'($urandom) : i[0];
			cmp_out <= i[2] ? i[0] : 1'($urandom);
			bus(1'b1, gst_pkg::ADDR_IRQ_CTRL, {4'h0, i[2], 3'h0});
			bus(1'b1, gst_pkg::ADDR_CONTROL, {i[1], 7'h41});
			t0 = ticks;
			repeat (40) @(posedge clk);
			chk(ticks > t0, i[1] ? i[0] : !i[0]);
		end
		bus(1'b1, gst_pkg::ADDR_CONTROL, 8'h00);
		$display("test gate done");
		mode_ok <= 1'b1;
		// crystal started with the timer still off
		bus(1'b1, gst_pkg::ADDR_CONTROL, 8'h08);
		repeat (4) @(posedge clk);
		rdchk(gst_pkg::ADDR_STATUS, 32'h13);
		chk(xrun, 1);
		// crystal rises every eight core clocks, counted on instruction ticks
		bus(1'b1, gst_pkg::ADDR_CONTROL, 8'h0b);
		gap(8);
		bus(1'b1, gst_pkg::ADDR_CONTROL, 8'h08);
		mode_ok <= 1'b0;
		repeat (4) @(posedge clk);
		rdchk(gst_pkg::ADDR_STATUS, 32'h0c);
		$display("test crystal done");
		// the timer is stopped for every count write
		bus(1'b1, gst_pkg::ADDR_COUNT_LOW, 8'h00);
		bus(1'b1, gst_pkg::ADDR_COUNT_HI, 8'h00);
		bus(1'b1, gst_pkg::ADDR_CONTROL, 8'h03);
		ext(8'd5);
		chk(mcount, 4);
		sleep <= 1'b1;
		ext(8'd3);
		chk(mcount, 4);
		bus(1'b1, gst_pkg::ADDR_CONTROL, 8'h07);
		ext(8'd5);
		chk(mcount, 9);
		cnt_chk();
		sleep <= 1'b0;
		$display("test external done");
		bus(1'b1, gst_pkg::ADDR_CONTROL, 8'h00);
		bus(1'b1, gst_pkg::ADDR_COUNT_LOW, 8'hff);
		bus(1'b1, gst_pkg::ADDR_COUNT_HI, 8'hff);
		bus(1'b1, gst_pkg::ADDR_IRQ_CTRL, 8'h03);
		bus(1'b1, gst_pkg::ADDR_CONTROL, 8'h01);
		repeat (12) @(posedge clk);
		sleep <= 1'b1;
		chk(irq, 0);
		rdchk(gst_pkg::ADDR_FLAG, 1);
		cnt_chk();
		bus(1'b1, gst_pkg::ADDR_IRQ_CTRL, 8'h07);
		chk(irq, 1);
		chk(wake, 1);
		bus(1'b1, gst_pkg::ADDR_FLAG, 8'h00);
		chk(irq, 0);
		sleep <= 1'b0;
		$display("test overflow done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
